// file: sbs_burst.v
// sbs_burst.v: two-bit burst address sequencer
`include "sbs_consts.vh"
module sbs_burst #(
  parameter LO_W = `SBS_LO_W
) (
  // clock and reset
  input  wire            mclk_i,
  input  wire            rstn_i,
  // control
  input  wire            load_i,
  input  wire [LO_W-1:0] load_lo_i,
  input  wire            step_i,
  input  wire            linear_i,
  // low address bits
  output wire [LO_W-1:0] cur_lo_o,
  output wire [LO_W-1:0] nxt_lo_o
);
  reg  [LO_W-1:0] start;
  reg  [LO_W-1:0] cnt;
  wire [LO_W-1:0] cnt_nx;

  // linear adds and wraps, interleaved flips bits
  function [LO_W-1:0] seq;
    input [LO_W-1:0] s;
    input [LO_W-1:0] c;
    input            lin;
    begin
      seq = lin ? (s + c) : (s ^ c);
    end
  endfunction

  assign cnt_nx   = cnt + {{(LO_W-1){1'b0}}, 1'b1};
  assign cur_lo_o = seq(start, cnt, linear_i);
  assign nxt_lo_o = seq(start, cnt_nx, linear_i);

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      start <= `SBS_LO_RST;
      cnt   <= `SBS_LO_RST;
    end else if (load_i) begin
      start <= load_lo_i;
      cnt   <= `SBS_LO_RST;
    end else if (step_i) begin
      cnt   <= cnt_nx;
    end
  end
endmodule // sbs_burst

// file: sbs_consts.vh
// sbs_consts.vh: shared constants of the synchronous burst sram
`ifndef SBS_CONSTS_VH
`define SBS_CONSTS_VH
`define SBS_ADDR_W      17
`define SBS_DATA_W      32
`define SBS_WORDS       131072
`define SBS_LANES       4
`define SBS_LANE_W      8
`define SBS_LO_W        2
`define SBS_FIFO_DEPTH  16
`define SBS_FIFO_W      53
`define SBS_FW_DATA_LSB 0
`define SBS_FW_ADDR_LSB 32
`define SBS_FW_BE_LSB   49
`define SBS_SYNC_N      3
`define SBS_MODE_RST    1'b1
`define SBS_SLEEP_RST   1'b0
`define SBS_LO_RST      2'h0
`define SBS_DOUT_RST    32'h0000_0000
`define SBS_CLK_NS      5
`endif

// file: sbs_fifo.v
// sbs_fifo.v: write posting fifo, power-of-two depth
`include "sbs_consts.vh"
module sbs_fifo #(
  parameter WIDTH = `SBS_FIFO_W,
  parameter DEPTH = `SBS_FIFO_DEPTH
) (
  // clock and reset
  input  wire             mclk_i,
  input  wire             rstn_i,
  // fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  localparam AW = $clog2(DEPTH);

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW:0]      wr_ptr;
  reg  [AW:0]      rd_ptr;
  wire             full;
  wire             empty;
  wire             push;
  wire             pop;

  // extra pointer bit tells full from empty
  assign full        = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty       = (wr_ptr == rd_ptr);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[rd_ptr[AW-1:0]];
  assign push        = in_valid_i && !full;
  assign pop         = out_valid_o && out_ready_i;

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
endmodule // sbs_fifo

// file: sbs_host.sv
// sbs_host.sv: processor or cache controller model on the burst bus
module sbs_host (
  // clock and device data
  input  wire logic        mclk_i,
  input  wire logic [31:0] data_io_o,
  input  wire logic        data_io_oe_o,
  // bus pins
  output logic [16:0] addr_i,
  output logic        chip_select_n_i, secondary_select_n_i, secondary_select_i,
  output logic        proc_addr_strobe_n_i, ctrl_addr_strobe_n_i, burst_advance_n_i,
  output logic        byte_write_strobe_0_n_i, byte_write_strobe_1_n_i,
  output logic        byte_write_strobe_2_n_i, byte_write_strobe_3_n_i,
  output logic        byte_write_gate_n_i, global_write_n_i,
  output wire  [31:0] data_io_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] d = 32'h0;
  logic        drv = 1'b0;
  // released bus shows the inverse of the last value, so stale data never matches
  assign data_io_i = data_io_oe_o ? data_io_o : (drv ? d : ~d);

  task automatic put(input logic p, c, input logic [2:0] s, input logic [16:0] a,
                     input logic v, input logic [5:0] w, input logic [31:0] x);
    {proc_addr_strobe_n_i, ctrl_addr_strobe_n_i} = {p, c};
    {chip_select_n_i, secondary_select_n_i, secondary_select_i} = s;
    {addr_i, burst_advance_n_i} = {a, v};
    {global_write_n_i, byte_write_gate_n_i, byte_write_strobe_3_n_i,
     byte_write_strobe_2_n_i, byte_write_strobe_1_n_i, byte_write_strobe_0_n_i} = w;
    drv = !w[5] || (!w[4] && w[3:0] != 4'hf);
    if (drv) d = x;
  endtask

  // one bus cycle, driven after the falling edge and held through the rising one
  task automatic cyc(input logic p, c, input logic [2:0] s, input logic [16:0] a,
                     input logic v, input logic [5:0] w, input logic [31:0] x);
    @(negedge mclk_i);
    put(p, c, s, a, v, w, x);
  endtask

  initial put(1'b1, 1'b1, 3'b001, 17'h0, 1'b1, 6'h3f, 32'h0);
endmodule // sbs_host

// file: sbs_sram.v
// sbs_sram.v: pipelined synchronous burst sram, 128k x 32
`include "sbs_consts.vh"
// Contract
// - all synchronous inputs are sampled only on the rising clock edge; global write and the byte write controls also gate the data drivers directly.
// - array holds 131072 words of 32 bits, 17-bit registered address.
// - two-bit counter makes the low address bits; upper bits stay registered.
// - burst timing is three clocks first, then one clock per word.
// - address and selects are latched only on an address strobe.
// - processor strobe with primary select low loads address, starts read.
// - controller strobe deselects or loads address; write controls pick read/write.
// - primary select active low; gates the processor strobe.
// - selected only with secondary low-select low and high-select high.
// - advance low steps the counter; high holds address as wait cycle.
// - order input low gives linear burst, high gives interleaved.
// - four byte strobes each write one data byte lane.
// - byte strobes count only with byte write gate low, else read.
// - global write low writes all four bytes regardless of others.
// - writes registered on chip and completed by internal self-timing.
// - during a qualified byte write the data drivers stay off.
// - output enable acts asynchronously; high floats the drivers.
// - address, control, input and output data pass pipeline registers.
// - deselect takes two cycles; no wait state between banks.
// - sleep high enters standby; keep low for normal operation.
// - interleaved burst visits start XOR 0, 1, 2, 3.
// - linear burst adds one per advance, wrapping modulo four.
module sbs_sram #(
  parameter ADDR_W     = `SBS_ADDR_W,
  parameter DATA_W     = `SBS_DATA_W,
  parameter WORDS      = `SBS_WORDS,
  parameter FIFO_DEPTH = `SBS_FIFO_DEPTH
) (
  // clock and reset
  input  wire              mclk_i,
  input  wire              rstn_i,
  // address and selects
  input  wire [ADDR_W-1:0] addr_i,
  input  wire              chip_select_n_i,
  input  wire              secondary_select_n_i,
  input  wire              secondary_select_i,
  // burst control
  input  wire              proc_addr_strobe_n_i,
  input  wire              ctrl_addr_strobe_n_i,
  input  wire              burst_advance_n_i,
  input  wire              burst_order_i,
  // write control
  input  wire              byte_write_strobe_0_n_i,
  input  wire              byte_write_strobe_1_n_i,
  input  wire              byte_write_strobe_2_n_i,
  input  wire              byte_write_strobe_3_n_i,
  input  wire              byte_write_gate_n_i,
  input  wire              global_write_n_i,
  // output control and standby
  input  wire              output_enable_n_i,
  input  wire              sleep_request_i,
  // data bus, split two-way pin
  input  wire [DATA_W-1:0] data_io_i,
  output wire [DATA_W-1:0] data_io_o,
  output wire              data_io_oe_o,
  // status
  output wire              wr_ready_o,
  output wire              sleep_active_o
);
  localparam LANES  = DATA_W / `SBS_LANE_W;
  localparam LO_W   = `SBS_LO_W;
  localparam FW     = ADDR_W + DATA_W + LANES;
  localparam ST_W   = 2;
  localparam [ST_W-1:0] ST_DESEL  = 2'h0;
  localparam [ST_W-1:0] ST_ACTIVE = 2'h1;
  localparam [ST_W-1:0] ST_SLEEP  = 2'h2;
  localparam [1:0] FILT_RST = {`SBS_MODE_RST, `SBS_SLEEP_RST};

  // byte enables from the write controls
  function [LANES-1:0] lane_mask;
    input             glob_n;
    input             gate_n;
    input [LANES-1:0] bw_n;
    begin
      if (!glob_n) begin
        lane_mask = {LANES{1'b1}};
      end else if (!gate_n) begin
        lane_mask = ~bw_n;
      end else begin
        lane_mask = {LANES{1'b0}};
      end
    end
  endfunction

  // full select: primary low, secondary low-select low, high-select high
  function chip_sel;
    input pri_n;
    input sec_n;
    input sec;
    begin
      chip_sel = !pri_n && !sec_n && sec;
    end
  endfunction

  reg  [ST_W-1:0]   state;
  reg  [ST_W-1:0]   next_state;
  reg  [ADDR_W-1:LO_W] addr_hi;
  reg  [ADDR_W-1:0] rd_addr;
  reg               rd_go;
  reg               drv;
  reg  [DATA_W-1:0] dout;
  reg  [DATA_W-1:0] mem [0:WORDS-1];
  integer           k;

  wire [1:0]        async_in;
  wire [1:0]        filt;
  wire              sleep_on;
  wire              linear;
  wire              awake;
  wire [LANES-1:0]  bw_n;
  wire [LANES-1:0]  lane_we;
  wire              wr_req;
  wire              byte_wr_q;
  wire              selected;
  wire              proc_start;
  wire              ctrl_start;
  wire              any_start;
  wire              do_start;
  wire              do_desel;
  wire              cont;
  wire              is_cycle;
  wire              is_write;
  wire              is_read;
  wire [LO_W-1:0]   cur_lo;
  wire [LO_W-1:0]   nxt_lo;
  wire [LO_W-1:0]   used_lo;
  wire [ADDR_W-1:0] used_addr;
  wire              fifo_in_ready;
  wire              fifo_out_valid;
  wire              fifo_out_ready;
  wire [FW-1:0]     fifo_in_data;
  wire [FW-1:0]     fifo_out_data;
  wire [DATA_W-1:0] pop_data;
  wire [ADDR_W-1:0] pop_addr;
  wire [LANES-1:0]  pop_be;
  wire              pop;

  // pin-level async inputs: three flops, change taken when 2nd and 3rd agree
  assign async_in = {burst_order_i, sleep_request_i};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_sync
      reg [`SBS_SYNC_N-1:0] sh;
      reg                   level;
      always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          sh    <= {`SBS_SYNC_N{FILT_RST[g]}};
          level <= FILT_RST[g];
        end else begin
          sh <= {sh[`SBS_SYNC_N-2:0], async_in[g]};
          if (sh[1] == sh[2]) begin
            level <= sh[2];
          end
        end
      end
      assign filt[g] = level;
    end
  endgenerate

  assign sleep_on = filt[0];
  assign linear   = !filt[1];
  assign awake    = !sleep_on && (state != ST_SLEEP);

  // write decode straight from the sampled pins
  assign bw_n      = {byte_write_strobe_3_n_i, byte_write_strobe_2_n_i,
                      byte_write_strobe_1_n_i, byte_write_strobe_0_n_i};
  assign lane_we   = lane_mask(global_write_n_i, byte_write_gate_n_i, bw_n);
  assign wr_req    = |lane_we;
  assign byte_wr_q = !byte_write_gate_n_i && !(&bw_n);

  // start decode; processor strobe means nothing while primary is high
  assign selected   = chip_sel(chip_select_n_i, secondary_select_n_i,
                               secondary_select_i);
  assign proc_start = !proc_addr_strobe_n_i && !chip_select_n_i;
  assign ctrl_start = !ctrl_addr_strobe_n_i && !proc_start;
  assign any_start  = proc_start || ctrl_start;
  assign do_start   = any_start && selected;
  assign do_desel   = any_start && !selected;
  assign cont       = (state == ST_ACTIVE) && !any_start;
  assign is_cycle   = awake && (do_start || cont);

  // a processor-strobe start is always a read
  assign is_write = is_cycle && wr_req && !(do_start && proc_start);
  assign is_read  = is_cycle && !is_write;

  // address used on this edge: external, next or current
  assign used_lo   = do_start ? addr_i[LO_W-1:0] :
                     (!burst_advance_n_i ? nxt_lo : cur_lo);
  assign used_addr = do_start ? addr_i : {addr_hi, used_lo};

  sbs_burst #(
    .LO_W (LO_W)
  ) u_burst (
    .mclk_i    (mclk_i),
    .rstn_i    (rstn_i),
    .load_i    (awake && do_start),
    .load_lo_i (addr_i[LO_W-1:0]),
    .step_i    (awake && cont && !burst_advance_n_i),
    .linear_i  (linear),
    .cur_lo_o  (cur_lo),
    .nxt_lo_o  (nxt_lo)
  );

  // upper address latched only on a qualified start
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_hi <= {(ADDR_W-LO_W){1'b0}};
    end else if (awake && do_start) begin
      addr_hi <= addr_i[ADDR_W-1:LO_W];
    end
  end

  // select state
  always @* begin
    next_state = state;
    case (state)
      ST_DESEL: begin
        if (sleep_on) begin
          next_state = ST_SLEEP;
        end else if (do_start) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (sleep_on) begin
          next_state = ST_SLEEP;
        end else if (do_desel) begin
          next_state = ST_DESEL;
        end
      end
      ST_SLEEP: begin
        if (!sleep_on) begin
          next_state = ST_DESEL;
        end
      end
      default: begin
        next_state = ST_DESEL;
      end
    endcase
  end

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= ST_DESEL;
    end else begin
      state <= next_state;
    end
  end

  // write posting: the fifo is the write input register stage
  assign fifo_in_data = {lane_we, used_addr, data_io_i};
  // drain stalls in standby, so posted writes wait for wake-up
  assign fifo_out_ready = awake;

  sbs_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_wfifo (
    .mclk_i      (mclk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (is_write),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  assign wr_ready_o = fifo_in_ready;
  assign pop_data   = fifo_out_data[`SBS_FW_DATA_LSB +: DATA_W];
  assign pop_addr   = fifo_out_data[`SBS_FW_ADDR_LSB +: ADDR_W];
  assign pop_be     = fifo_out_data[`SBS_FW_BE_LSB +: LANES];
  assign pop        = fifo_out_valid && fifo_out_ready;

  // self-timed array write, one posted word per cycle
  always @(posedge mclk_i) begin
    if (pop) begin
      for (k = 0; k < LANES; k = k + 1) begin
        if (pop_be[k]) begin
          mem[pop_addr][k*`SBS_LANE_W +: `SBS_LANE_W] <=
            pop_data[k*`SBS_LANE_W +: `SBS_LANE_W];
        end
      end
    end
  end

  // read address register stage
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_go   <= 1'b0;
      rd_addr <= {ADDR_W{1'b0}};
    end else begin
      rd_go <= is_read;
      if (is_read) begin
        rd_addr <= used_addr;
      end
    end
  end

  // output register; a write one edge earlier is already in the array
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dout <= `SBS_DOUT_RST;
      drv  <= 1'b0;
    end else begin
      drv <= rd_go;
      if (rd_go) begin
        dout <= mem[rd_addr];
      end
    end
  end

  // drivers: output enable is not sampled, it gates directly
  assign data_io_o    = dout;
  assign data_io_oe_o = drv && !output_enable_n_i && !byte_wr_q &&
                        !(!global_write_n_i) && awake;
  assign sleep_active_o = !awake;
endmodule // sbs_sram

// file: sbs_sram_monitor.sv
// sbs_sram_monitor.sv: port-level assertions for the burst sram
module sbs_sram_monitor #(
  parameter ADDR_W = 17,
  parameter DATA_W = 32
) (
  // clock, reset and bus pins
  input wire logic              mclk_i, rstn_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic              chip_select_n_i, secondary_select_n_i, secondary_select_i,
  input wire logic              proc_addr_strobe_n_i, ctrl_addr_strobe_n_i,
  input wire logic              burst_advance_n_i, burst_order_i,
  input wire logic              byte_write_strobe_0_n_i, byte_write_strobe_1_n_i,
  input wire logic              byte_write_strobe_2_n_i, byte_write_strobe_3_n_i,
  input wire logic              byte_write_gate_n_i, global_write_n_i,
  input wire logic              output_enable_n_i, sleep_request_i,
  // data and status
  input wire logic [DATA_W-1:0] data_io_i, data_io_o,
  input wire logic              data_io_oe_o, wr_ready_o, sleep_active_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire sel_ok = !chip_select_n_i && !secondary_select_n_i && secondary_select_i;
  wire any_bw = !(byte_write_strobe_0_n_i && byte_write_strobe_1_n_i
                  && byte_write_strobe_2_n_i && byte_write_strobe_3_n_i);
  wire wr_now = !global_write_n_i || (!byte_write_gate_n_i && any_bw);
  wire rd_go  = !proc_addr_strobe_n_i && sel_ok && !sleep_active_o;
  // processor strobe only counts with the primary select low
  wire desel  = (!ctrl_addr_strobe_n_i || (!proc_addr_strobe_n_i && !chip_select_n_i))
                && !sel_ok && !sleep_active_o;
  wire no_go  = ctrl_addr_strobe_n_i && (proc_addr_strobe_n_i || chip_select_n_i);

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  chk_oe_float: assert property (output_enable_n_i |-> !data_io_oe_o)
    else $error("data driven with output enable high");
  chk_write_float: assert property (wr_now |-> !data_io_oe_o)
    else $error("data driven during a write");
  chk_sleep_float: assert property (sleep_active_o |-> !data_io_oe_o)
    else $error("data driven in standby");
  chk_read_drive: assert property (rd_go ##2 (!output_enable_n_i && !wr_now
    && !sleep_active_o) |-> data_io_oe_o)
    else $error("read data not driven two edges after start");
  chk_desel_two: assert property (desel ##1 no_go |=> !data_io_oe_o)
    else $error("drive still on two cycles after deselect");
  chk_fifo_room: assert property (wr_ready_o)
    else $error("write buffer reported full");
  chk_sleep_enter: assert property (sleep_request_i [*4] |-> ##[0:2] sleep_active_o)
    else $error("standby not entered");
  chk_sleep_leave: assert property (!sleep_request_i [*6] |-> !sleep_active_o)
    else $error("standby not left");
endmodule // sbs_sram_monitor

bind sbs_sram sbs_sram_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_mon (.*);

// file: sbs_sram_test.sv
// sbs_sram_test.sv: self-checking testbench of the burst sram
module sbs_sram_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0]  NOW = 6'h3f;
  localparam logic [5:0]  WR_ALL = 6'h1f;
  localparam logic [16:0] HI  = 17'h0a5c4;
  logic        mclk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        output_enable_n_i = 1'b0;
  logic        sleep_request_i = 1'b0;
  logic        burst_order_i = 1'b1;
  wire  [16:0] addr_i;
  wire         chip_select_n_i, secondary_select_n_i, secondary_select_i;
  wire         proc_addr_strobe_n_i, ctrl_addr_strobe_n_i, burst_advance_n_i;
  wire         byte_write_strobe_0_n_i, byte_write_strobe_1_n_i;
  wire         byte_write_strobe_2_n_i, byte_write_strobe_3_n_i;
  wire         byte_write_gate_n_i, global_write_n_i;
  wire  [31:0] data_io_i, data_io_o;
  wire         data_io_oe_o, wr_ready_o, sleep_active_o;
  int          bad_count = 0;
  int          n_checks = 0;
  logic [31:0] mm [0:3];

  always #2.5 mclk_i = ~mclk_i;
  sbs_sram u_dut (.*);
  sbs_host h (.*);

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [1:0] vis(input logic [1:0] s, input int j, input logic lin);
    return lin ? s + 2'(j) : s ^ 2'(j);
  endfunction

  // wait cycle; a different address shows the strobe alone latches it
  task automatic nop();
    h.cyc(1, 1, 3'b001, ~HI, 1, NOW, 0);
  endtask

  task automatic rd(input logic [16:0] a, input logic [31:0] e);
    h.cyc(0, 1, 3'b001, a, 1, NOW, 0);
    nop();
    nop();
    #1 chk("read word", e, data_io_o);
  endtask

  task automatic t_wr_burst(input logic [1:0] s);
    h.cyc(1, 0, 3'b001, {HI[16:2], s}, 1, WR_ALL, mm[s]);
    for (int j = 1; j < 4; j++) h.cyc(1, 1, 3'b001, ~HI, 0, WR_ALL, mm[vis(s, j, 0)]);
    nop();
  endtask

  task automatic t_rd_burst(input logic [1:0] s, input logic lin, wt);
    int k;
    h.cyc(0, 1, 3'b001, {HI[16:2], s}, 1, NOW, 0);
    h.cyc(1, 1, 3'b001, ~HI, wt, NOW, 0);
    for (int j = 0; j < 4; j++) begin
      h.cyc(1, 1, 3'b001, ~HI, j > 1, NOW, 0);
      k = wt ? (j ? j - 1 : 0) : j;
      #1 chk("burst word", mm[vis(s, k, lin)], data_io_o);
      chk("burst drive", 1, data_io_oe_o);
    end
  endtask

  task automatic t_bytes();
    logic [31:0] e;
    h.cyc(1, 0, 3'b001, 17'h310, 1, WR_ALL, 32'h1122_3344);
    h.cyc(1, 0, 3'b001, 17'h310, 1, 6'h30, 32'hffff_ffff);
    rd(17'h310, 32'h1122_3344);
    for (int k = 0; k < 4; k++) begin
      h.cyc(0, 1, 3'b001, 17'h310, 1, NOW, 0);
      nop();
      h.cyc(1, 0, 3'b001, 17'h310, 1, {2'b10, ~(4'h1 << k)}, 32'hcafe_f00d);
      #1 chk("write float", 0, data_io_oe_o);
      e = 32'h1122_3344;
      e[8*k +: 8] = 8'(32'hcafe_f00d >> (8 * k));
      rd(17'h310, e);
      h.cyc(1, 0, 3'b001, 17'h310, 1, WR_ALL, 32'h1122_3344);
    end
  endtask

  task automatic t_desel();
    for (int i = 0; i < 3; i++) begin
      h.cyc(0, 1, 3'b001, {HI[16:2], 2'b00}, 1, NOW, 0);
      h.cyc(1, 0, 3'b001 ^ (3'b100 >> i), HI, 1, NOW, 0);
      h.cyc(1, 1, 3'b001, ~HI, 0, NOW, 0);
      #1 chk("held word", mm[0], data_io_o);
      chk("held drive", 1, data_io_oe_o);
      h.cyc(0, 1, 3'b101, HI, 1, NOW, 0);
      #1 chk("released drive", 0, data_io_oe_o);
      nop();
      nop();
      #1 chk("ignored strobe", 0, data_io_oe_o);
    end
  endtask

  task automatic wait_flag(input logic v);
    int n;
    n = 0;
    while (sleep_active_o !== v && n < 20) begin
      nop();
      n++;
    end
    chk("standby flag", v, sleep_active_o);
    if (n == 20) results();
  endtask

  task automatic t_sleep();
    sleep_request_i = 1'b1;
    wait_flag(1);
    h.cyc(1, 0, 3'b001, HI, 1, WR_ALL, 32'hbad0_0000);
    nop();
    sleep_request_i = 1'b0;
    wait_flag(0);
    rd({HI[16:2], 2'b00}, mm[0]);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 4; i++) mm[i] = 32'h0a0b_0c00 + i;
    repeat (10) @(posedge mclk_i);
    @(negedge mclk_i);
    rstn_i = 1'b1;
    #1 chk("reset drive", 0, data_io_oe_o);
    chk("reset room", 1, wr_ready_o);
    chk("reset standby", 0, sleep_active_o);
    t_wr_burst(2'd1);
    t_rd_burst(2'd2, 0, 0);
    nop();
    output_enable_n_i = 1'b1;
    #1 chk("oe float", 0, data_io_oe_o);
    output_enable_n_i = 1'b0;
    // order pin is synchronised, so give it a few edges to land
    burst_order_i = 1'b0;
    repeat (6) nop();
    t_rd_burst(2'd3, 1, 0);
    t_rd_burst(2'd1, 1, 1);
    burst_order_i = 1'b1;
    repeat (6) nop();
    t_bytes();
    h.cyc(0, 1, 3'b001, 17'h1ffff, 1, NOW, 0);
    h.cyc(1, 1, 3'b001, ~HI, 1, WR_ALL, 32'h600d_0017);
    nop();
    rd(17'h1ffff, 32'h600d_0017);
    t_desel();
    t_sleep();
    results();
  end
endmodule // sbs_sram_test
